//--- hdl/rcf_pkg.sv
`default_nettype none
package rcf_pkg;
  localparam int unsigned RCF_AW = 6;
  localparam int unsigned RCF_NREG = 48;
  localparam int unsigned RCF_DIVW = 15;

  // Device register offsets.
  localparam logic [5:0] RCF_SECONDS = 6'h01;
  localparam logic [5:0] RCF_MINUTES = 6'h02;
  localparam logic [5:0] RCF_DAYS = 6'h04;
  localparam logic [5:0] RCF_WEEKDAYS = 6'h05;
  localparam logic [5:0] RCF_MONTHS = 6'h06;
  localparam logic [5:0] RCF_ALARM_FIRST = 6'h08;
  localparam logic [5:0] RCF_ALARM_LAST = 6'h0f;
  localparam logic [5:0] RCF_TSTAMP_FIRST = 6'h11;
  localparam logic [5:0] RCF_TSTAMP_LAST = 6'h22;
  localparam logic [5:0] RCF_PIN_IO = 6'h27;
  localparam logic [5:0] RCF_FUNCTION_CONTROL = 6'h28;
  localparam logic [5:0] RCF_EVENT_FLAGS = 6'h2b;
  localparam logic [5:0] RCF_RESET_COMMAND = 6'h2f;

  // Non-zero reset values.
  localparam logic [7:0] RCF_SECONDS_RST = 8'h80;
  localparam logic [7:0] RCF_DAYS_RST = 8'h01;
  localparam logic [7:0] RCF_WEEKDAYS_RST = 8'h06;
  localparam logic [7:0] RCF_MONTHS_RST = 8'h01;

  // Reset command codes.
  localparam logic [7:0] RCF_CMD_SOFT_RESET = 8'h2c;
  localparam logic [7:0] RCF_CMD_CLR_PRESC = 8'ha4;
  localparam logic [7:0] RCF_CMD_CLR_TSTAMP = 8'h25;
  localparam logic [7:0] RCF_CMD_CLR_BOTH = 8'ha5;
  localparam logic [7:0] RCF_CMD_NONE = 8'h00;

  // Function control fields.
  localparam int unsigned RCF_COF_LSB = 0;
  localparam logic [2:0] RCF_COF_OSC = 3'h0;
  localparam logic [2:0] RCF_COF_1HZ = 3'h6;
  localparam logic [2:0] RCF_COF_OFF = 3'h7;
  localparam int unsigned RCF_DIV_1HZ_BIT = 14;

  // Pin control fields.
  localparam int unsigned RCF_INTAPM_LSB = 0;
  localparam int unsigned RCF_TSPM_LSB = 2;
  localparam int unsigned RCF_CLK_OUT_INVERT_BIT = 6;
  localparam int unsigned RCF_CLK_PIN_DISABLE_BIT = 7;
  localparam logic [1:0] RCF_INTERRUPT_A_PIN_CLK = 2'h0;
  localparam logic [1:0] RCF_INTERRUPT_A_PIN_BAT = 2'h1;
  localparam logic [1:0] RCF_INTERRUPT_A_PIN_IRQ = 2'h2;
  localparam logic [1:0] RCF_TS_CLK = 2'h1;

  // Host register offsets and command bits.
  localparam logic [1:0] RCF_H_CMD = 2'h0;
  localparam logic [1:0] RCF_H_FCLR = 2'h1;
  localparam logic [1:0] RCF_H_ADDR = 2'h2;
  localparam logic [1:0] RCF_H_DATA = 2'h3;
  localparam int unsigned RCF_H_SR_BIT = 0;
  localparam int unsigned RCF_H_CPR_BIT = 1;
  localparam int unsigned RCF_H_CTS_BIT = 2;

  typedef logic [RCF_NREG-1:0][7:0] rcf_regs_t;

  function automatic rcf_regs_t rcf_reg_image();
    rcf_regs_t img;
    img = '0;
    img[RCF_SECONDS] = RCF_SECONDS_RST;
    img[RCF_DAYS] = RCF_DAYS_RST;
    img[RCF_WEEKDAYS] = RCF_WEEKDAYS_RST;
    img[RCF_MONTHS] = RCF_MONTHS_RST;
    return img;
  endfunction

  localparam rcf_regs_t RCF_REG_RST = rcf_reg_image();
endpackage
`default_nettype wire

//--- hdl/rcf_if.sv
`default_nettype none
interface rcf_if;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd,
                input rdata);
endinterface
`default_nettype wire

//--- hdl/rcf_host.sv
`default_nettype none
module rcf_host
  import rcf_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  rcf_if.host bus,
  input wire logic [1:0] usr_addr_in,
  input wire logic [7:0] usr_wdata_in,
  input wire logic usr_wr_in,
  input wire logic usr_rd_in,
  output logic [7:0] usr_rdata_out
);
  typedef struct packed {
    logic [5:0] dev_addr;
    logic [7:0] last_cmd;
    logic sel_dev;
    logic [7:0] rdata;
  } rcf_host_s;

  rcf_host_s st_reg;
  rcf_host_s st_next;
  logic [7:0] cmd_code;

  // Soft reset already includes both clears, so it wins.
  function automatic logic [7:0] rcf_cmd_code(input logic [7:0] req);
    if (req[RCF_H_SR_BIT]) begin
      return RCF_CMD_SOFT_RESET; // [RL10]
    end else if (req[RCF_H_CPR_BIT] && req[RCF_H_CTS_BIT]) begin
      return RCF_CMD_CLR_BOTH; // [RL13]
    end else if (req[RCF_H_CPR_BIT]) begin
      return RCF_CMD_CLR_PRESC; // [RL11]
    end else if (req[RCF_H_CTS_BIT]) begin
      return RCF_CMD_CLR_TSTAMP; // [RL12]
    end
    return RCF_CMD_NONE;
  endfunction

  always_comb begin
    st_next = st_reg;
    cmd_code = rcf_cmd_code(usr_wdata_in);
    bus.addr = st_reg.dev_addr;
    bus.wdata = usr_wdata_in;
    bus.wr = 1'b0;
    bus.rd = 1'b0;
    if (usr_wr_in) begin
      case (usr_addr_in)
        RCF_H_CMD: begin
          bus.addr = RCF_RESET_COMMAND;
          bus.wdata = cmd_code;
          bus.wr = (cmd_code != RCF_CMD_NONE);
          st_next.last_cmd = cmd_code;
        end
        RCF_H_FCLR: begin
          // A one in the mask clears that flag; zeros leave flags alone.
          bus.addr = RCF_EVENT_FLAGS;
          bus.wdata = ~usr_wdata_in; // [RL8]
          bus.wr = 1'b1;
        end
        RCF_H_ADDR: st_next.dev_addr = usr_wdata_in[RCF_AW-1:0];
        default: bus.wr = 1'b1;
      endcase
    end
    st_next.sel_dev = usr_rd_in && (usr_addr_in == RCF_H_DATA);
    bus.rd = st_next.sel_dev;
    st_next.rdata = '0;
    if (usr_rd_in) begin
      case (usr_addr_in)
        RCF_H_CMD: st_next.rdata = st_reg.last_cmd;
        RCF_H_ADDR: st_next.rdata = {2'b00, st_reg.dev_addr};
        default: st_next.rdata = '0;
      endcase
    end
    usr_rdata_out = st_reg.sel_dev ? bus.rdata : st_reg.rdata;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

//--- hdl/rcf_device.sv
// Summary of operation
// (RL1) Select codes 0-6 pick clock; 7 stops.
// (RL2) Frequency select resets to full oscillator rate.
// (RL3) Clock pin runs at power-on; disable holds low.
// (RL4) Invert bit flips clock except code seven.
// (RL5) Divided clocks have equal high and low.
// (RL6) One hertz output ignores calibration pulses.
// (RL7) Eight flags in fixed order, reset zero.
// (RL8) Flags sticky; writes AND into flags.
// (RL9) OR of flags read as minutes MSB.
// (RL10) Code 2Ch soft resets, clears prescaler, timestamps.
// (RL11) Code A4h clears only the prescaler.
// (RL12) Code 25h clears only the timestamps.
// (RL13) Code A5h clears prescaler and timestamps.
// (RL14) Other reset command values do nothing.
// (RL15) Reset at power-on and on soft reset.
// (RL16) Reset gives calendar mode, 2000-01-01, Saturday.
// (RL17) Reset enables battery switch, lower threshold.
// (RL18) Reset gives clock on both pins, timestamp off.
// (RL19) Reset keeps alarms, loads fixed image elsewhere.
// (RL20) Timestamp clear zeroes addresses 11h to 22h.
// (RL21) Interrupt pin clock released while on battery.
// (RL22) Flag set beats a simultaneous clearing write.
// (RL23) Dividers are a counter on oscillator edges.
//
// The address-and-strobe port was left to the implementer.
`default_nettype none
module rcf_device
  import rcf_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  rcf_if.dev bus,
  input wire logic osc_clk_in,
  input wire logic on_battery_in,
  input wire logic [7:0] flag_set_in,
  input wire logic int_a_req_in,
  output logic clk_pin_out,
  output logic ts_pin_out,
  output logic ts_pin_oe_n_out,
  output logic interrupt_a_pin_out,
  output logic interrupt_a_pin_oe_n_out,
  output logic sec_tick_out,
  output logic soft_reset_out,
  output logic presc_clr_out,
  output logic tstamp_clr_out
);
  typedef struct packed {
    rcf_regs_t regs;
    logic [RCF_DIVW-1:0] div;
    logic [RCF_DIVW-1:0] presc;
    logic osc_q;
    logic [7:0] rdata;
    logic clk_pin;
    logic ts_pin_oe_n;
    logic ts_pin;
    logic interrupt_a_pin_oe_n;
    logic sec_tick;
    logic soft_rst;
    logic presc_clr;
    logic tstamp_clr;
  } rcf_dev_s;

  // Pins start released and the clock appears within two edges.
  localparam rcf_dev_s RCF_DEV_RST = '{
    regs: RCF_REG_RST,
    ts_pin_oe_n: 1'b1,
    interrupt_a_pin_oe_n: 1'b1,
    default: '0
  };

  rcf_dev_s st_reg;
  rcf_dev_s st_next;
  logic osc_rise;
  logic flags_wr;
  logic event_monitor;
  logic [2:0] clock_out_freq_sel;
  logic [1:0] int_a_pin_mode_sel;
  logic [1:0] ts_pin_mode_sel;
  logic clk_pin_disable;
  logic clk_out_invert;
  logic clk_sel;

  // Divider bit n runs at 32768 / 2^(n+1) Hz with a 50:50 duty cycle.
  function automatic logic rcf_clk_pick(input logic [2:0] cof,
                                        input logic osc,
                                        input logic [RCF_DIVW-1:0] div);
    if (cof == RCF_COF_OSC) begin
      return osc; // [RL5]
    end else if (cof == RCF_COF_1HZ) begin
      return div[RCF_DIV_1HZ_BIT]; // [RL1]
    end else if (cof == RCF_COF_OFF) begin
      return 1'b0; // [RL1]
    end
    return div[cof - 3'h1]; // [RL1] [RL5]
  endfunction

  function automatic logic rcf_in_range(input logic [5:0] a,
                                        input logic [5:0] lo,
                                        input logic [5:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.sec_tick = 1'b0;
    st_next.soft_rst = 1'b0;
    st_next.presc_clr = 1'b0;
    st_next.tstamp_clr = 1'b0;
    st_next.rdata = '0;
    st_next.osc_q = osc_clk_in;
    osc_rise = osc_clk_in && !st_reg.osc_q;
    clock_out_freq_sel =
      st_reg.regs[RCF_FUNCTION_CONTROL][RCF_COF_LSB +: 3];
    int_a_pin_mode_sel = st_reg.regs[RCF_PIN_IO][RCF_INTAPM_LSB +: 2];
    ts_pin_mode_sel = st_reg.regs[RCF_PIN_IO][RCF_TSPM_LSB +: 2];
    clk_pin_disable = st_reg.regs[RCF_PIN_IO][RCF_CLK_PIN_DISABLE_BIT];
    clk_out_invert = st_reg.regs[RCF_PIN_IO][RCF_CLK_OUT_INVERT_BIT];
    event_monitor = |st_reg.regs[RCF_EVENT_FLAGS]; // [RL9]

    // The clock-out divider is separate from the time prescaler, so
    // calibration and A4h/A5h prescaler clears never disturb the output clock; soft reset zeroes it.
    if (osc_rise) begin
      st_next.div = RCF_DIVW'(st_reg.div + 1'b1); // [RL23] [RL6]
      st_next.presc = RCF_DIVW'(st_reg.presc + 1'b1);
      st_next.sec_tick = &st_reg.presc;
    end

    if (bus.rd) begin
      if (bus.addr == RCF_MINUTES) begin
        st_next.rdata = {event_monitor, st_reg.regs[RCF_MINUTES][6:0]};
      end else if (bus.addr != RCF_RESET_COMMAND &&
                   bus.addr < RCF_AW'(RCF_NREG)) begin
        st_next.rdata = st_reg.regs[bus.addr];
      end
    end

    if (bus.wr && bus.addr != RCF_EVENT_FLAGS &&
        bus.addr != RCF_RESET_COMMAND && bus.addr < RCF_AW'(RCF_NREG)) begin
      st_next.regs[bus.addr] = bus.wdata;
    end

    // Writing zero clears a flag; a set event in the same cycle wins.
    flags_wr = bus.wr && (bus.addr == RCF_EVENT_FLAGS);
    st_next.regs[RCF_EVENT_FLAGS] =
      (flags_wr ? (st_reg.regs[RCF_EVENT_FLAGS] & bus.wdata)
                : st_reg.regs[RCF_EVENT_FLAGS]) // [RL8]
      | flag_set_in; // [RL22] [RL7]

    if (bus.wr && bus.addr == RCF_RESET_COMMAND) begin
      case (bus.wdata)
        RCF_CMD_SOFT_RESET: begin
          st_next.soft_rst = 1'b1; // [RL15]
          st_next.presc_clr = 1'b1; // [RL10]
          st_next.tstamp_clr = 1'b1;
        end
        RCF_CMD_CLR_PRESC: st_next.presc_clr = 1'b1; // [RL11]
        RCF_CMD_CLR_TSTAMP: st_next.tstamp_clr = 1'b1; // [RL12]
        RCF_CMD_CLR_BOTH: begin
          st_next.presc_clr = 1'b1; // [RL13]
          st_next.tstamp_clr = 1'b1;
        end
        default: st_next.tstamp_clr = 1'b0; // [RL14]
      endcase
    end

    if (st_next.presc_clr) begin
      st_next.presc = '0;
      st_next.sec_tick = 1'b0;
    end
    if (st_next.tstamp_clr) begin
      for (int i = 0; i < RCF_NREG; i++) begin
        if (rcf_in_range(6'(i), RCF_TSTAMP_FIRST, RCF_TSTAMP_LAST)) begin
          st_next.regs[i] = '0; // [RL20]
        end
      end
    end
    if (st_next.soft_rst) begin
      st_next.div = '0;
      for (int i = 0; i < RCF_NREG; i++) begin
        if (!rcf_in_range(6'(i), RCF_ALARM_FIRST, RCF_ALARM_LAST)) begin
          st_next.regs[i] = RCF_REG_RST[i]; // [RL19] [RL16] [RL17] [RL2]
        end
      end
    end

    // Pins follow the registered divider state so they move together.
    clk_sel = rcf_clk_pick(clock_out_freq_sel, st_reg.osc_q, st_reg.div)
              ^ (clk_out_invert &&
                 clock_out_freq_sel != RCF_COF_OFF); // [RL4]
    st_next.clk_pin = clk_pin_disable ? 1'b0 : clk_sel; // [RL3]
    st_next.ts_pin_oe_n = (ts_pin_mode_sel != RCF_TS_CLK); // [RL18]
    st_next.ts_pin = (ts_pin_mode_sel == RCF_TS_CLK) && clk_sel;
    case (int_a_pin_mode_sel)
      RCF_INTERRUPT_A_PIN_CLK: begin
        st_next.interrupt_a_pin_oe_n = on_battery_in || // [RL21]
                            clock_out_freq_sel == RCF_COF_OFF || // [RL1]
                            clk_sel; // [RL18]
      end
      RCF_INTERRUPT_A_PIN_BAT: st_next.interrupt_a_pin_oe_n = !on_battery_in;
      RCF_INTERRUPT_A_PIN_IRQ: st_next.interrupt_a_pin_oe_n = !int_a_req_in;
      default: st_next.interrupt_a_pin_oe_n = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= RCF_DEV_RST; // [RL15]
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    bus.rdata = st_reg.rdata;
    clk_pin_out = st_reg.clk_pin;
    ts_pin_out = st_reg.ts_pin;
    ts_pin_oe_n_out = st_reg.ts_pin_oe_n;
    interrupt_a_pin_out = 1'b0;
    interrupt_a_pin_oe_n_out = st_reg.interrupt_a_pin_oe_n;
    sec_tick_out = st_reg.sec_tick;
    soft_reset_out = st_reg.soft_rst;
    presc_clr_out = st_reg.presc_clr;
    tstamp_clr_out = st_reg.tstamp_clr;
  end
endmodule
`default_nettype wire

//--- dv/rcf_asserts.sv
`default_nettype none
module rcf_asserts
  import rcf_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic img_reg, cts_reg, frd_reg, event_monitor_reg, cmd_w;
  assign cmd_w = wr && addr == RCF_RESET_COMMAND;
  // Remembers whether the reset image or a timestamp clear is still intact.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      img_reg <= 1'b1;
      cts_reg <= 1'b1;
      frd_reg <= 1'b0;
      event_monitor_reg <= 1'b0;
    end else begin
      frd_reg <= rd && addr == RCF_EVENT_FLAGS;
      if (wr) begin
        img_reg <= cmd_w && wdata == RCF_CMD_SOFT_RESET;
        event_monitor_reg <= 1'b0;
      end else if (frd_reg && rdata != 8'h00) begin
        event_monitor_reg <= 1'b1;
      end
      if (cmd_w && wdata inside {RCF_CMD_SOFT_RESET, RCF_CMD_CLR_TSTAMP,
          RCF_CMD_CLR_BOTH}) begin
        cts_reg <= 1'b1;
      end else if (wr && addr inside {[RCF_TSTAMP_FIRST:RCF_TSTAMP_LAST]}) begin
        cts_reg <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  a_event_monitor_follows:
    assert property (rd && addr == RCF_MINUTES && event_monitor_reg |=> rdata[7])
    else $error("event monitor low while flags set");
  a_tstamp_zeroed:
    assert property (rd && cts_reg && addr inside
      {[RCF_TSTAMP_FIRST:RCF_TSTAMP_LAST]} |=> rdata == 8'h00)
    else $error("timestamp byte not cleared");
  a_image_seconds:
    assert property (img_reg && $past(rd) && $past(addr) == RCF_SECONDS
      |-> rdata == RCF_SECONDS_RST)
    else $error("seconds differ from reset image");
  a_image_days:
    assert property (rd && img_reg && addr == RCF_DAYS
      |-> ##1 rdata == RCF_DAYS_RST)
    else $error("days differ from reset image");
  a_image_weekday:
    assert property (rd && img_reg && addr == RCF_WEEKDAYS
      |=> rdata == RCF_WEEKDAYS_RST)
    else $error("weekday differs from reset image");
  a_image_function:
    assert property (rd && img_reg && addr == RCF_FUNCTION_CONTROL
      |=> rdata[2:0] == RCF_COF_OSC)
    else $error("clock select not at full rate after reset");
  a_image_pins:
    assert property (rd && img_reg && addr == RCF_PIN_IO |=> rdata == 8'h00)
    else $error("pin control not cleared by reset");
  a_image_battery:
    assert property (rd && img_reg && addr == 6'h26 |=> rdata == 8'h00)
    else $error("battery control not cleared by reset");
endmodule
`default_nettype wire

//--- dv/tb.sv
`default_nettype none
module tb
  import rcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] ua = 2'h0;
  logic [7:0] uwd = 8'h00;
  logic uwr = 1'b0;
  logic urd = 1'b0;
  logic osc = 1'b0;
  logic osc_run = 1'b1;
  logic osc_ph = 1'b0;
  logic on_bat = 1'b0;
  logic ireq = 1'b0;
  logic [7:0] fset = 8'h00;
  logic cpin_q = 1'b0;
  logic [7:0] urdata, c;
  logic cpin, tsp, ts_oe_n, iap, ia_oe_n, tick, srp, cpp, ctp, sr, cp, ct;
  logic [7:0] codes [7] = '{RCF_CMD_SOFT_RESET, RCF_CMD_CLR_PRESC,
    RCF_CMD_CLR_TSTAMP, RCF_CMD_CLR_BOTH, 8'h2d, 8'h00, 8'hff};
  int num_errors = 0;
  int tests_run = 0;
  int n_tk = 0;
  int cycles = 0;
  int n_rise = 0, n_hi = 0, n_sr = 0, n_cp = 0, n_ct = 0, r0, h0, t0;
  rcf_if bus();
  rcf_host rcf_host_i(.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .bus(bus), .usr_addr_in(ua), .usr_wdata_in(uwd), .usr_wr_in(uwr),
    .usr_rd_in(urd), .usr_rdata_out(urdata));
  rcf_device rcf_device_i(.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .bus(bus), .osc_clk_in(osc), .on_battery_in(on_bat),
    .flag_set_in(fset), .int_a_req_in(ireq), .clk_pin_out(cpin),
    .ts_pin_out(tsp), .ts_pin_oe_n_out(ts_oe_n), .interrupt_a_pin_out(iap),
    .interrupt_a_pin_oe_n_out(ia_oe_n), .sec_tick_out(tick),
    .soft_reset_out(srp), .presc_clr_out(cpp), .tstamp_clr_out(ctp));
  rcf_asserts rcf_asserts_i(.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
    .rdata(bus.rdata));
  always #20 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    osc_ph <= ~osc_ph;
    if (!osc_run) osc <= 1'b0;
    else if (osc_ph) osc <= ~osc;
    cpin_q <= cpin;
    n_rise += int'(cpin === 1'b1 && cpin_q === 1'b0);
    n_hi += int'(cpin === 1'b1);
    n_sr += int'(srp === 1'b1);
    n_cp += int'(cpp === 1'b1);
    n_ct += int'(ctp === 1'b1);
    n_tk += int'(tick === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic hw(input logic [1:0] a, input logic [7:0] d);
    ua <= a;
    uwd <= d;
    uwr <= 1'b1;
    @(posedge clk_sys_in);
    uwr <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic hr(input logic [1:0] a, output logic [7:0] d);
    ua <= a;
    urd <= 1'b1;
    @(posedge clk_sys_in);
    urd <= 1'b0;
    #1 d = urdata;
    @(posedge clk_sys_in);
  endtask
  task automatic dwr(input logic [5:0] a, input logic [7:0] d);
    hw(RCF_H_ADDR, {2'h0, a});
    hw(RCF_H_DATA, d);
  endtask
  task automatic dchk(string n, input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    hw(RCF_H_ADDR, {2'h0, a});
    hr(RCF_H_DATA, d);
    chk(n, d, e);
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_sys_in);
    #1;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    chk("ts_off", 8'(ts_oe_n), 8'h01);
    dchk("days", RCF_DAYS, RCF_DAYS_RST);
    dchk("pins", RCF_PIN_IO, 8'h00);
    dchk("seconds", RCF_SECONDS, RCF_SECONDS_RST);
    dchk("weekday", RCF_WEEKDAYS, RCF_WEEKDAYS_RST);
    dchk("flags", RCF_EVENT_FLAGS, 8'h00);
    dchk("function", RCF_FUNCTION_CONTROL, 8'h00);
    dchk("battery", 6'h26, 8'h00);
    for (int k = 0; k < 6; k++) begin
      if (k > 0) dwr(RCF_FUNCTION_CONTROL, 8'(k));
      settle();
      r0 = n_rise;
      h0 = n_hi;
      repeat (512) @(posedge clk_sys_in);
      #1 r0 = n_rise - r0;
      h0 = n_hi - h0;
      chk("rate", 8'(r0 >= (128 >> k) - 1 && r0 <= (128 >> k) + 1), 8'h01);
      if (k > 0) chk("duty", 8'(h0 >= 256 - (2 << k) && h0 <= 256 + (2 << k)), 8'h01);
    end
    dwr(RCF_FUNCTION_CONTROL, {5'h00, RCF_COF_1HZ});
    settle();
    r0 = n_rise;
    repeat (512) @(posedge clk_sys_in);
    #1 chk("slow", 8'(n_rise - r0), 8'h00);
    dwr(RCF_FUNCTION_CONTROL, {5'h00, RCF_COF_OFF});
    dwr(RCF_PIN_IO, 8'h40);
    settle();
    r0 = n_hi;
    settle();
    chk("off_high", 8'(n_hi - r0), 8'h00);
    chk("interrupt_a_pin_off", 8'(ia_oe_n), 8'h01);
    osc_run <= 1'b0;
    dwr(RCF_FUNCTION_CONTROL, 8'h00);
    settle();
    chk("inverted", 8'(cpin), 8'h01);
    dwr(RCF_PIN_IO, 8'hc0);
    settle();
    chk("disabled", 8'(cpin), 8'h00);
    dwr(RCF_PIN_IO, 8'h00);
    settle();
    chk("interrupt_a_pin_clk", 8'(ia_oe_n), 8'h00);
    on_bat <= 1'b1;
    settle();
    chk("interrupt_a_pin_bat", 8'(ia_oe_n), 8'h01);
    dwr(RCF_PIN_IO, {6'h00, RCF_INTERRUPT_A_PIN_BAT});
    settle();
    chk("interrupt_a_pin_bmode", 8'(ia_oe_n), 8'h00);
    on_bat <= 1'b0;
    ireq <= 1'b1;
    dwr(RCF_PIN_IO, {6'h00, RCF_INTERRUPT_A_PIN_IRQ});
    settle();
    chk("interrupt_a_pin_irq", 8'(ia_oe_n), 8'h00);
    ireq <= 1'b0;
    dwr(RCF_PIN_IO, 8'h44);
    settle();
    chk("ts_drive", 8'(ts_oe_n), 8'h00);
    chk("ts_level", 8'(tsp), 8'h01);
    chk("ia_data", 8'(iap), 8'h00);
    dwr(6'h31, 8'hff);
    dchk("unmapped", 6'h31, 8'h00);
    fset <= 8'h81;
    @(posedge clk_sys_in);
    fset <= 8'h00;
    dchk("flags", RCF_EVENT_FLAGS, 8'h81);
    dchk("minutes", RCF_MINUTES, 8'h80);
    dwr(RCF_EVENT_FLAGS, 8'hfe);
    dchk("flags_and", RCF_EVENT_FLAGS, 8'h80);
    hw(RCF_H_FCLR, 8'h80);
    dchk("flags_clr", RCF_EVENT_FLAGS, 8'h00);
    dchk("minutes", RCF_MINUTES, 8'h00);
    hw(RCF_H_ADDR, {2'h0, RCF_EVENT_FLAGS});
    ua <= RCF_H_DATA;
    uwd <= 8'h00;
    uwr <= 1'b1;
    fset <= 8'h01;
    @(posedge clk_sys_in);
    uwr <= 1'b0;
    fset <= 8'h00;
    @(posedge clk_sys_in);
    dchk("flags_set", RCF_EVENT_FLAGS, 8'h01);
    hw(RCF_H_CMD, 8'h01);
    dchk("flags_sr", RCF_EVENT_FLAGS, 8'h00);
    for (int i = 0; i < 7; i++) begin
      c = codes[i];
      sr = c == RCF_CMD_SOFT_RESET;
      cp = sr || c == RCF_CMD_CLR_PRESC || c == RCF_CMD_CLR_BOTH;
      ct = sr || c == RCF_CMD_CLR_TSTAMP || c == RCF_CMD_CLR_BOTH;
      dwr(RCF_TSTAMP_LAST, 8'h5a);
      dwr(RCF_ALARM_LAST, 8'h33);
      dwr(RCF_FUNCTION_CONTROL, 8'h03);
      r0 = n_sr;
      h0 = n_cp;
      t0 = n_ct;
      dwr(RCF_RESET_COMMAND, c);
      settle();
      chk("sr_pulse", 8'(n_sr - r0), 8'(sr));
      chk("cpr_pulse", 8'(n_cp - h0), 8'(cp));
      chk("cts_pulse", 8'(n_ct - t0), 8'(ct));
      dchk("tstamp", RCF_TSTAMP_LAST, ct ? 8'h00 : 8'h5a);
      dchk("alarm", RCF_ALARM_LAST, 8'h33);
      dchk("func", RCF_FUNCTION_CONTROL, sr ? 8'h00 : 8'h03);
    end
    for (int i = 1; i < 4; i++) begin
      r0 = n_sr;
      h0 = n_cp;
      t0 = n_ct;
      hw(RCF_H_CMD, 8'(2 * i));
      settle();
      chk("host_sr", 8'(n_sr - r0), 8'h00);
      chk("host_cpr", 8'(n_cp - h0), 8'(i % 2));
      chk("host_cts", 8'(n_ct - t0), 8'(i / 2));
      hr(RCF_H_CMD, c);
      chk("last_cmd", c, codes[i]);
    end
    chk("no_tick", 8'(n_tk), 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
